/* logic/ice_cost_top.sv */
// instruction execution cycle cost estimator, top level
// How it works
// - scaled base uses base mode cost
// - register base forces five cycles
// - stack-top base forces four cycles
// - index cost 5/7/8/10 added to base
// - byte transfer zero or three
// - word transfer four times bus minus one
// - dword transfer four times bus minus one
// - sized transfer picks by length
// - length factor 1, 2, 4
// - float size factor 1 or 2
// - integer transfer 2 or 4 cycles
// - flag set adds address cost
// - flag clear adds no address cost
// - length entry times bytes
// - range entry gives min and max
// - flush entry: flush point, total
// - flush adds next fetch cycles
// - single fetch: point plus six plus fetch
// - multi fetch: point plus five plus fetch
// - immediate uses register overhead by default
// - total sums all contributions
// - float adds max of parallel, coprocessor+3
`timescale 1ns/1ps
`default_nettype none

module ice_cost_top
(
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  input  wire logic                          in_valid,
  input  wire logic                          op1_addr_calc,
  input  wire logic                          op1_is_scaled,
  input  wire ice_pkg::ice_mode_type         op1_base_mode,
  input  wire logic [ice_pkg::COST_W-1:0]    op1_plain_cost,
  input  wire ice_pkg::ice_scale_type        op1_scale,
  input  wire ice_pkg::ice_loc_type          op1_loc,
  input  wire logic [ice_pkg::BUS_W-1:0]     op1_bus_cycles,
  input  wire logic [ice_pkg::CNT_W-1:0]     op1_xfer_cnt,
  input  wire logic                          op2_addr_calc,
  input  wire logic                          op2_is_scaled,
  input  wire ice_pkg::ice_mode_type         op2_base_mode,
  input  wire logic [ice_pkg::COST_W-1:0]    op2_plain_cost,
  input  wire ice_pkg::ice_scale_type        op2_scale,
  input  wire ice_pkg::ice_loc_type          op2_loc,
  input  wire logic [ice_pkg::BUS_W-1:0]     op2_bus_cycles,
  input  wire logic [ice_pkg::CNT_W-1:0]     op2_xfer_cnt,
  input  wire logic [ice_pkg::CNT_W-1:0]     fix_byte_cnt,
  input  wire logic [ice_pkg::CNT_W-1:0]     fix_word_cnt,
  input  wire logic [ice_pkg::CNT_W-1:0]     fix_dword_cnt,
  input  wire logic [ice_pkg::BUS_W-1:0]     fix_bus_cycles,
  input  wire ice_pkg::ice_len_type          op_len,
  input  wire logic [ice_pkg::CNT_W-1:0]     len_units,
  input  wire ice_pkg::ice_ovh_type          ovh_fmt,
  input  wire logic [ice_pkg::COST_W-1:0]    ovh_n1,
  input  wire logic [ice_pkg::COST_W-1:0]    ovh_n2,
  input  wire logic [ice_pkg::COST_W-1:0]    ovh_reg_n1,
  input  wire logic [ice_pkg::COST_W-1:0]    ovh_reg_n2,
  input  wire logic                          imm_own_ovh,
  input  wire logic [ice_pkg::COST_W-1:0]    fetch_cycles,
  input  wire logic                          fetch_multi,
  input  wire logic                          is_float,
  input  wire logic                          float_long,
  input  wire logic [ice_pkg::CNT_W-1:0]     float_xfer_cnt,
  input  wire logic                          float_both_dirs,
  input  wire logic [ice_pkg::CNT_W-1:0]     int_xfer_cnt,
  input  wire ice_pkg::ice_len_type          int_len,
  input  wire logic [ice_pkg::COST_W-1:0]    parallel_cpu_cycles,
  input  wire logic [ice_pkg::COST_W-1:0]    coprocessor_exec_cycles,
  output logic      [ice_pkg::COST_W-1:0]    total_exec_min_r,
  output logic      [ice_pkg::COST_W-1:0]    total_exec_max_r,
  output logic      [ice_pkg::COST_W-1:0]    flush_point_r,
  output logic                               result_valid_r
);

  localparam int CW = ice_pkg::COST_W;

  logic          rst_meta_r;
  logic          rst_n_r;
  logic [CW-1:0] first_operand_address_cost;
  logic [CW-1:0] second_operand_address_cost;
  logic [CW-1:0] op1_base_cost;
  logic [CW-1:0] op2_base_cost;
  logic [CW-1:0] op1_idx_cost;
  logic [CW-1:0] op2_idx_cost;
  logic [CW-1:0] op1_byte;
  logic [CW-1:0] op1_word;
  logic [CW-1:0] op1_dword;
  logic [CW-1:0] op1_sized;
  logic [CW-1:0] op2_byte;
  logic [CW-1:0] op2_word;
  logic [CW-1:0] op2_dword;
  logic [CW-1:0] op2_sized;
  logic [CW-1:0] fix_byte;
  logic [CW-1:0] fix_word;
  logic [CW-1:0] fix_dword;
  logic [CW-1:0] len_factor;
  logic [CW-1:0] float_size_factor;
  logic [CW-1:0] integer_transfer_cost;
  logic [CW-1:0] float_transfer_cost;
  logic [CW-1:0] xfer_sum;
  logic [CW-1:0] len_cost;
  logic [CW-1:0] sel_n1;
  logic [CW-1:0] sel_n2;
  logic [CW-1:0] ovh_min;
  logic [CW-1:0] ovh_max;
  logic [CW-1:0] fpu_wait;
  logic [CW-1:0] fp_cost;
  logic [CW-1:0] sum_min_nxt;
  logic [CW-1:0] sum_max_nxt;
  logic          use_reg_ovh;

  // small count times a cost, truncated to the datapath width
  function automatic logic [CW-1:0] times(input logic [ice_pkg::CNT_W-1:0] n, input logic [CW-1:0] c);
    times = c * {{(CW-ice_pkg::CNT_W){1'b0}}, n};
  endfunction

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // address cost of each operand
  ice_ea_cost u_ea1 (
    .addr_calc              (op1_addr_calc),
    .is_scaled              (op1_is_scaled),
    .base_mode              (op1_base_mode),
    .plain_cost             (op1_plain_cost),
    .scale                  (op1_scale),
    .base_mode_cost         (op1_base_cost),
    .index_scale_cost       (op1_idx_cost),
    .effective_address_cost (first_operand_address_cost)
  );

  ice_ea_cost u_ea2 (
    .addr_calc              (op2_addr_calc),
    .is_scaled              (op2_is_scaled),
    .base_mode              (op2_base_mode),
    .plain_cost             (op2_plain_cost),
    .scale                  (op2_scale),
    .base_mode_cost         (op2_base_cost),
    .index_scale_cost       (op2_idx_cost),
    .effective_address_cost (second_operand_address_cost)
  );

  // transfer costs: one per operand, one for fixed-size columns
  ice_xfer_cost u_xf1 (
    .loc                 (op1_loc),
    .op_len              (op_len),
    .bus_cycle_count     (op1_bus_cycles),
    .byte_transfer_cost  (op1_byte),
    .word_transfer_cost  (op1_word),
    .dword_transfer_cost (op1_dword),
    .sized_transfer_cost (op1_sized)
  );

  ice_xfer_cost u_xf2 (
    .loc                 (op2_loc),
    .op_len              (op_len),
    .bus_cycle_count     (op2_bus_cycles),
    .byte_transfer_cost  (op2_byte),
    .word_transfer_cost  (op2_word),
    .dword_transfer_cost (op2_dword),
    .sized_transfer_cost (op2_sized)
  );

  // fixed-size columns always address memory
  ice_xfer_cost u_xfx (
    .loc                 (ice_pkg::LOC_MEM),
    .op_len              (ice_pkg::LEN_DWORD),
    .bus_cycle_count     (fix_bus_cycles),
    .byte_transfer_cost  (fix_byte),
    .word_transfer_cost  (fix_word),
    .dword_transfer_cost (fix_dword),
    .sized_transfer_cost ()
  );

  always_comb
  begin
    case (op_len)
      ice_pkg::LEN_BYTE: len_factor = ice_pkg::LFACT_BYTE;
      ice_pkg::LEN_WORD: len_factor = ice_pkg::LFACT_WORD;
      default:           len_factor = ice_pkg::LFACT_DWORD;
    endcase
  end

  assign len_cost = times(len_units, len_factor);

  assign float_size_factor = float_long ? ice_pkg::FSIZE_LONG : ice_pkg::FSIZE_STD;

  // per-word cost, doubled for long when both directions count
  assign float_transfer_cost = float_both_dirs ? ice_pkg::FLT_PER_WORD * float_size_factor
                                               : ice_pkg::FLT_PER_WORD;

  assign integer_transfer_cost = (int_len == ice_pkg::LEN_DWORD) ? ice_pkg::INT_XFER_LONG
                                                                 : ice_pkg::INT_XFER_SHORT;

  // all transfers; unused unit bits of op1/op2 byte forms are for checks only
  assign xfer_sum = times(op1_xfer_cnt, op1_sized) + times(op2_xfer_cnt, op2_sized)
                  + times(fix_byte_cnt, fix_byte) + times(fix_word_cnt, fix_word)
                  + times(fix_dword_cnt, fix_dword) + times(float_xfer_cnt, float_transfer_cost)
                  + times(int_xfer_cnt, integer_transfer_cost);

  // immediate borrows the register entry unless it has its own
  assign use_reg_ovh = !imm_own_ovh && (op1_loc == ice_pkg::LOC_IMM || op2_loc == ice_pkg::LOC_IMM);
  assign sel_n1 = use_reg_ovh ? ovh_reg_n1 : ovh_n1;
  assign sel_n2 = use_reg_ovh ? ovh_reg_n2 : ovh_n2;

  // overhead bounds by entry form
  always_comb
  begin
    case (ovh_fmt)
      ice_pkg::OVH_RANGE:
      begin
        ovh_min = sel_n1;
        ovh_max = sel_n2;
      end
      ice_pkg::OVH_FLUSH:
      begin
        ovh_min = sel_n1 + (fetch_multi ? ice_pkg::FLUSH_MULTI : ice_pkg::FLUSH_ONE) + fetch_cycles;
        ovh_max = ovh_min;
      end
      default:
      begin
        ovh_min = sel_n1;
        ovh_max = sel_n1;
      end
    endcase
  end

  // larger of parallel work and coprocessor plus hand-off
  assign fpu_wait = coprocessor_exec_cycles + ice_pkg::FPU_HANDOFF;
  assign fp_cost  = !is_float ? '0 : (parallel_cpu_cycles > fpu_wait) ? parallel_cpu_cycles : fpu_wait;

  // sum of contributions; wraps silently past the width
  assign sum_min_nxt = first_operand_address_cost + second_operand_address_cost + xfer_sum
                     + len_cost + ovh_min + fp_cost;
  assign sum_max_nxt = first_operand_address_cost + second_operand_address_cost + xfer_sum
                     + len_cost + ovh_max + fp_cost;

  // result register, one clock after acceptance
  always_ff @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      total_exec_min_r <= '0;
      total_exec_max_r <= '0;
      flush_point_r    <= '0;
      result_valid_r   <= 1'b0;
    end
    else
    begin
      result_valid_r <= in_valid;
      if (in_valid)
      begin
        total_exec_min_r <= sum_min_nxt;
        total_exec_max_r <= sum_max_nxt;
        flush_point_r    <= (ovh_fmt == ice_pkg::OVH_FLUSH) ? sel_n1 : '0;
      end
    end
  end

  // checks on the computed costs
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n_r);

  chk_valid_latency: assert property (in_valid
    |=> result_valid_r && total_exec_min_r == $past(sum_min_nxt))
    else $error("result not registered one clock after input");
  chk_idle_valid: assert property (!in_valid |=> !result_valid_r)
    else $error("valid raised without input");
  chk_reg_base: assert property (op1_is_scaled && op1_addr_calc
    && op1_base_mode == ice_pkg::MODE_REGISTER && op1_scale == ice_pkg::SCALE_DWORD
    |-> first_operand_address_cost == 16'h000d)
    else $error("scaled register base with dword index is not 13");
  chk_stack_base: assert property (op2_is_scaled && op2_addr_calc
    && op2_base_mode == ice_pkg::MODE_STACK_TOP && op2_scale == ice_pkg::SCALE_QUAD
    |-> second_operand_address_cost == 16'h000e)
    else $error("scaled stack-top base with quad index is not 14");
  chk_index_byte: assert property (op1_is_scaled && op1_addr_calc
    && op1_base_mode == ice_pkg::MODE_ABSOLUTE && op1_scale == ice_pkg::SCALE_BYTE
    |-> first_operand_address_cost == op1_plain_cost + 16'h0005)
    else $error("byte index not five over base");
  chk_no_address: assert property (!op2_addr_calc |-> second_operand_address_cost == '0)
    else $error("address cost added with flag clear");
  chk_byte_mem: assert property (op1_loc == ice_pkg::LOC_MEM |-> op1_byte == 16'h0003)
    else $error("memory byte transfer not three");
  chk_word_bus: assert property (op2_loc == ice_pkg::LOC_MEM && op2_bus_cycles == 4'h2
    |-> op2_word == 16'h0007 && op2_dword == 16'h0007)
    else $error("two bus cycles not seven");
  chk_reg_zero: assert property (op1_loc != ice_pkg::LOC_MEM |-> op1_sized == '0)
    else $error("register operand charged a transfer");
  chk_flush_one: assert property (in_valid && ovh_fmt == ice_pkg::OVH_FLUSH && !fetch_multi
    |-> ovh_min == sel_n1 + 16'h0006 + fetch_cycles)
    else $error("single fetch flush not point plus six");
  chk_range_order: assert property (in_valid && ovh_fmt == ice_pkg::OVH_RANGE
    |=> total_exec_max_r - total_exec_min_r == $past(ovh_max) - $past(ovh_min))
    else $error("range bounds not carried to outputs");
  chk_fp_max: assert property (is_float |-> fp_cost >= parallel_cpu_cycles && fp_cost >= fpu_wait)
    else $error("float cost below either bound");

  cov_flush: cover property (in_valid && ovh_fmt == ice_pkg::OVH_FLUSH ##1 result_valid_r);
  cov_scaled: cover property (in_valid && op1_is_scaled && op1_addr_calc);
  cov_float: cover property (in_valid && is_float && fpu_wait > parallel_cpu_cycles);
  cov_back2back: cover property (in_valid ##1 in_valid ##1 result_valid_r);

endmodule // ice_cost_top

`default_nettype wire

/* logic/ice_ea_cost.sv */
// effective-address cost of one operand, scaled-indexed included
`timescale 1ns/1ps
`default_nettype none

module ice_ea_cost
(
  input  wire logic                          addr_calc,
  input  wire logic                          is_scaled,
  input  wire ice_pkg::ice_mode_type         base_mode,
  input  wire logic [ice_pkg::COST_W-1:0]    plain_cost,
  input  wire ice_pkg::ice_scale_type        scale,
  output logic      [ice_pkg::COST_W-1:0]    base_mode_cost,
  output logic      [ice_pkg::COST_W-1:0]    index_scale_cost,
  output logic      [ice_pkg::COST_W-1:0]    effective_address_cost
);

  logic [ice_pkg::COST_W-1:0] raw_cost;

  // base part; plain_cost is the mode's own table cost
  always_comb
  begin
    if (base_mode == ice_pkg::MODE_REGISTER)
      base_mode_cost = ice_pkg::BASE_REGISTER;
    else if (base_mode == ice_pkg::MODE_STACK_TOP)
      base_mode_cost = ice_pkg::BASE_STACK_TOP;
    else
      base_mode_cost = plain_cost;
  end

  always_comb
  begin
    case (scale)
      ice_pkg::SCALE_BYTE:  index_scale_cost = ice_pkg::IDX_BYTE;
      ice_pkg::SCALE_WORD:  index_scale_cost = ice_pkg::IDX_WORD;
      ice_pkg::SCALE_DWORD: index_scale_cost = ice_pkg::IDX_DWORD;
      default:              index_scale_cost = ice_pkg::IDX_QUAD;
    endcase
  end

  assign raw_cost = is_scaled ? base_mode_cost + index_scale_cost : plain_cost;

  assign effective_address_cost = addr_calc ? raw_cost : '0;

endmodule // ice_ea_cost

`default_nettype wire

/* logic/ice_pkg.sv */
// constants, encodings and widths shared by the cycle cost estimator
`default_nettype none

package ice_pkg;

  // datapath widths
  localparam int COST_W = 16;
  localparam int CNT_W  = 2;
  localparam int BUS_W  = 4;

  // addressing mode of a scaled-indexed base, or of a plain operand
  typedef enum logic [3:0] {
    MODE_IMMEDIATE  = 4'h0,
    MODE_ABSOLUTE   = 4'h1,
    MODE_EXTERNAL   = 4'h2,
    MODE_MEM_REL    = 4'h3,
    MODE_REGISTER   = 4'h4,
    MODE_REG_REL    = 4'h5,
    MODE_MEM_SPACE  = 4'h6,
    MODE_STACK_TOP  = 4'h7
  } ice_mode_type;

  // index scale of a scaled-indexed operand
  typedef enum logic [1:0] {
    SCALE_BYTE  = 2'h0,
    SCALE_WORD  = 2'h1,
    SCALE_DWORD = 2'h2,
    SCALE_QUAD  = 2'h3
  } ice_scale_type;

  // where an operand lives
  typedef enum logic [1:0] {
    LOC_REG = 2'h0,
    LOC_IMM = 2'h1,
    LOC_MEM = 2'h2
  } ice_loc_type;

  // operation length
  typedef enum logic [1:0] {
    LEN_BYTE  = 2'h0,
    LEN_WORD  = 2'h1,
    LEN_DWORD = 2'h2
  } ice_len_type;

  // form of an internal-overhead table entry
  typedef enum logic [1:0] {
    OVH_PLAIN = 2'h0,
    OVH_RANGE = 2'h1,
    OVH_FLUSH = 2'h2
  } ice_ovh_type;

  // scaled-indexed base overrides and index costs
  localparam logic [COST_W-1:0] BASE_REGISTER  = 16'h0005;
  localparam logic [COST_W-1:0] BASE_STACK_TOP = 16'h0004;
  localparam logic [COST_W-1:0] IDX_BYTE      = 16'h0005;
  localparam logic [COST_W-1:0] IDX_WORD      = 16'h0007;
  localparam logic [COST_W-1:0] IDX_DWORD     = 16'h0008;
  localparam logic [COST_W-1:0] IDX_QUAD      = 16'h000a;

  // operand transfer costs
  localparam logic [COST_W-1:0] BYTE_MEM_COST = 16'h0003;
  localparam logic [COST_W-1:0] TOP_PER_BUS   = 16'h0004;
  localparam logic [COST_W-1:0] TOP_ADJUST    = 16'h0001;

  // length and float size factors
  localparam logic [COST_W-1:0] LFACT_BYTE    = 16'h0001;
  localparam logic [COST_W-1:0] LFACT_WORD    = 16'h0002;
  localparam logic [COST_W-1:0] LFACT_DWORD   = 16'h0004;
  localparam logic [COST_W-1:0] FSIZE_STD     = 16'h0001;
  localparam logic [COST_W-1:0] FSIZE_LONG    = 16'h0002;

  // coprocessor transfer and hand-off costs
  localparam logic [COST_W-1:0] INT_XFER_SHORT = 16'h0002;
  localparam logic [COST_W-1:0] INT_XFER_LONG  = 16'h0004;
  localparam logic [COST_W-1:0] FLT_PER_WORD  = 16'h0004;
  localparam logic [COST_W-1:0] FPU_HANDOFF   = 16'h0003;

  // queue flush refetch adders
  localparam logic [COST_W-1:0] FLUSH_ONE     = 16'h0006;
  localparam logic [COST_W-1:0] FLUSH_MULTI   = 16'h0005;

endpackage : ice_pkg

`default_nettype wire

/* logic/ice_xfer_cost.sv */
// memory operand transfer costs for one operand
`timescale 1ns/1ps
`default_nettype none

module ice_xfer_cost
(
  input  wire ice_pkg::ice_loc_type          loc,
  input  wire ice_pkg::ice_len_type          op_len,
  input  wire logic [ice_pkg::BUS_W-1:0]     bus_cycle_count,
  output logic      [ice_pkg::COST_W-1:0]    byte_transfer_cost,
  output logic      [ice_pkg::COST_W-1:0]    word_transfer_cost,
  output logic      [ice_pkg::COST_W-1:0]    dword_transfer_cost,
  output logic      [ice_pkg::COST_W-1:0]    sized_transfer_cost
);

  logic in_mem;

  // bus-cycle driven cost, shared by word and double-word
  function automatic logic [ice_pkg::COST_W-1:0] bus_cost(input logic [ice_pkg::BUS_W-1:0] n);
    logic [ice_pkg::COST_W-1:0] wide;
    wide = {{(ice_pkg::COST_W-ice_pkg::BUS_W){1'b0}}, n};
    bus_cost = ice_pkg::TOP_PER_BUS * wide - ice_pkg::TOP_ADJUST;
  endfunction

  // register and immediate operands move nothing on the bus
  assign in_mem = (loc == ice_pkg::LOC_MEM);

  assign byte_transfer_cost  = in_mem ? ice_pkg::BYTE_MEM_COST : '0;
  assign word_transfer_cost  = in_mem ? bus_cost(bus_cycle_count) : '0;
  assign dword_transfer_cost = in_mem ? bus_cost(bus_cycle_count) : '0;

  always_comb
  begin
    if (!in_mem)
      sized_transfer_cost = '0;
    else if (op_len == ice_pkg::LEN_BYTE)
      sized_transfer_cost = byte_transfer_cost;
    else if (op_len == ice_pkg::LEN_WORD)
      sized_transfer_cost = word_transfer_cost;
    else
      sized_transfer_cost = dword_transfer_cost;
  end

endmodule // ice_xfer_cost

`default_nettype wire

/* testbench/testbench.sv */
// self-checking random bench for the cycle cost estimator top
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic mclk, resetn, in_valid, fetch_multi, is_float, float_long, float_both_dirs, imm_own_ovh;
  logic op1_addr_calc, op1_is_scaled, op2_addr_calc, op2_is_scaled;
  ice_pkg::ice_mode_type  op1_base_mode, op2_base_mode;
  ice_pkg::ice_scale_type op1_scale, op2_scale;
  ice_pkg::ice_loc_type   op1_loc, op2_loc;
  ice_pkg::ice_len_type   op_len, int_len;
  ice_pkg::ice_ovh_type   ovh_fmt;
  logic [3:0]  op1_bus_cycles, op2_bus_cycles, fix_bus_cycles;
  logic [1:0]  op1_xfer_cnt, op2_xfer_cnt, fix_byte_cnt, fix_word_cnt, fix_dword_cnt, len_units;
  logic [1:0]  float_xfer_cnt, int_xfer_cnt;
  logic [15:0] op1_plain_cost, op2_plain_cost, ovh_n1, ovh_n2, ovh_reg_n1, ovh_reg_n2, fetch_cycles;
  logic [15:0] parallel_cpu_cycles, coprocessor_exec_cycles, total_exec_min_r, total_exec_max_r, flush_point_r;
  logic        result_valid_r;
  logic [15:0] exp_min, exp_max, exp_fp;
  logic        exp_v;
  int          seed, failures, n_compared, cycles;

  ice_cost_top ice_cost_top_i (
    .mclk(mclk), .resetn(resetn), .in_valid(in_valid), .op1_addr_calc(op1_addr_calc),
    .op1_is_scaled(op1_is_scaled), .op1_base_mode(op1_base_mode), .op1_plain_cost(op1_plain_cost),
    .op1_scale(op1_scale), .op1_loc(op1_loc), .op1_bus_cycles(op1_bus_cycles), .op1_xfer_cnt(op1_xfer_cnt),
    .op2_addr_calc(op2_addr_calc), .op2_is_scaled(op2_is_scaled), .op2_base_mode(op2_base_mode),
    .op2_plain_cost(op2_plain_cost), .op2_scale(op2_scale), .op2_loc(op2_loc),
    .op2_bus_cycles(op2_bus_cycles), .op2_xfer_cnt(op2_xfer_cnt), .fix_byte_cnt(fix_byte_cnt),
    .fix_word_cnt(fix_word_cnt), .fix_dword_cnt(fix_dword_cnt), .fix_bus_cycles(fix_bus_cycles),
    .op_len(op_len), .len_units(len_units), .ovh_fmt(ovh_fmt), .ovh_n1(ovh_n1), .ovh_n2(ovh_n2),
    .ovh_reg_n1(ovh_reg_n1), .ovh_reg_n2(ovh_reg_n2), .imm_own_ovh(imm_own_ovh), .fetch_cycles(fetch_cycles),
    .fetch_multi(fetch_multi), .is_float(is_float), .float_long(float_long), .float_xfer_cnt(float_xfer_cnt),
    .float_both_dirs(float_both_dirs), .int_xfer_cnt(int_xfer_cnt), .int_len(int_len),
    .parallel_cpu_cycles(parallel_cpu_cycles), .coprocessor_exec_cycles(coprocessor_exec_cycles),
    .total_exec_min_r(total_exec_min_r), .total_exec_max_r(total_exec_max_r),
    .flush_point_r(flush_point_r), .result_valid_r(result_valid_r)
  );

  // free-running 8 ns clock
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  function automatic logic [15:0] rnd(input logic [15:0] mask);
    rnd = 16'($random(seed)) & mask;
  endfunction

  // address cost of one operand
  function automatic logic [15:0] ea_cost(input logic calc, input logic sc, input ice_pkg::ice_mode_type m,
                                          input logic [15:0] plain, input ice_pkg::ice_scale_type s);
    logic [15:0] base;
    logic [15:0] idx;
    base = (m == ice_pkg::MODE_REGISTER) ? 16'h0005 : (m == ice_pkg::MODE_STACK_TOP) ? 16'h0004 : plain;
    idx  = (s == ice_pkg::SCALE_BYTE) ? 16'h0005 : (s == ice_pkg::SCALE_WORD) ? 16'h0007 :
           (s == ice_pkg::SCALE_DWORD) ? 16'h0008 : 16'h000a;
    ea_cost = !calc ? 16'h0000 : sc ? base + idx : plain;
  endfunction

  // memory transfer cost, zero unless in memory
  function automatic logic [15:0] xfer(input ice_pkg::ice_loc_type loc, input ice_pkg::ice_len_type len,
                                       input logic [3:0] bus);
    if (loc != ice_pkg::LOC_MEM)
      xfer = 16'h0000;
    else
      xfer = (len == ice_pkg::LEN_BYTE) ? 16'h0003 : {12'h000, bus} * 16'h0004 - 16'h0001;
  endfunction

  // expected outputs for the descriptor now at the inputs
  task automatic calc_expected();
    logic [15:0] f, fcost, icost, lf, n1, n2, fp, sum;
    f     = float_long ? 16'h0002 : 16'h0001;
    fcost = float_both_dirs ? 16'h0004 * f : 16'h0004;
    icost = (int_len == ice_pkg::LEN_DWORD) ? 16'h0004 : 16'h0002;
    lf  = (op_len == ice_pkg::LEN_BYTE) ? 16'h0001 : (op_len == ice_pkg::LEN_WORD) ? 16'h0002 : 16'h0004;
    n1  = ((op1_loc == ice_pkg::LOC_IMM || op2_loc == ice_pkg::LOC_IMM) && !imm_own_ovh) ? ovh_reg_n1 : ovh_n1;
    n2  = ((op1_loc == ice_pkg::LOC_IMM || op2_loc == ice_pkg::LOC_IMM) && !imm_own_ovh) ? ovh_reg_n2 : ovh_n2;
    fp  = !is_float ? 16'h0000 : (parallel_cpu_cycles > coprocessor_exec_cycles + 16'h0003) ?
          parallel_cpu_cycles : coprocessor_exec_cycles + 16'h0003;
    sum = ea_cost(op1_addr_calc, op1_is_scaled, op1_base_mode, op1_plain_cost, op1_scale)
        + ea_cost(op2_addr_calc, op2_is_scaled, op2_base_mode, op2_plain_cost, op2_scale)
        + 16'(op1_xfer_cnt) * xfer(op1_loc, op_len, op1_bus_cycles)
        + 16'(op2_xfer_cnt) * xfer(op2_loc, op_len, op2_bus_cycles)
        + 16'(fix_byte_cnt) * 16'h0003 + (16'(fix_word_cnt) + 16'(fix_dword_cnt)) *
          ({12'h000, fix_bus_cycles} * 16'h0004 - 16'h0001)
        + 16'(float_xfer_cnt) * fcost + 16'(int_xfer_cnt) * icost + 16'(len_units) * lf + fp;
    exp_v = in_valid;
    if (in_valid)
    begin
      exp_fp  = (ovh_fmt == ice_pkg::OVH_FLUSH) ? n1 : 16'h0000;
      exp_min = (ovh_fmt == ice_pkg::OVH_FLUSH) ? sum + n1 + (fetch_multi ? 16'h0005 : 16'h0006) + fetch_cycles
                                                : sum + n1;
      exp_max = (ovh_fmt == ice_pkg::OVH_RANGE) ? sum + n2 : exp_min;
    end
  endtask

  // random descriptor; corner mode forces a scaled op1 base and flush entries
  task automatic drive(input logic crn, input logic vld);
    in_valid        <= vld & (crn | (rnd(16'h0003) != 16'h0000));
    op1_addr_calc   <= crn | rnd(16'h0001) != 16'h0000;
    op1_is_scaled   <= crn | rnd(16'h0001) != 16'h0000;
    op1_base_mode   <= crn ? (rnd(16'h0001) != 0 ? ice_pkg::MODE_REGISTER : ice_pkg::MODE_STACK_TOP)
                           : ice_pkg::ice_mode_type'(4'(rnd(16'h0007)));
    op2_addr_calc   <= rnd(16'h0001) != 16'h0000;
    op2_is_scaled   <= rnd(16'h0001) != 16'h0000;
    op2_base_mode   <= ice_pkg::ice_mode_type'(4'(rnd(16'h0007)));
    op1_scale       <= ice_pkg::ice_scale_type'(2'(rnd(16'h0003)));
    op2_scale       <= ice_pkg::ice_scale_type'(2'(rnd(16'h0003)));
    op1_loc         <= ice_pkg::ice_loc_type'(2'(rnd(16'h0003) % 16'h0003));
    op2_loc         <= ice_pkg::ice_loc_type'(2'(rnd(16'h0003) % 16'h0003));
    op_len          <= ice_pkg::ice_len_type'(2'(rnd(16'h0003) % 16'h0003));
    int_len         <= ice_pkg::ice_len_type'(2'(rnd(16'h0003) % 16'h0003));
    ovh_fmt         <= crn ? ice_pkg::OVH_FLUSH : ice_pkg::ice_ovh_type'(2'(rnd(16'h0003) % 16'h0003));
    {op1_bus_cycles, op2_bus_cycles, fix_bus_cycles} <= 12'(rnd(16'h0fff));
    {op1_xfer_cnt, op2_xfer_cnt, fix_byte_cnt, fix_word_cnt} <= 8'(rnd(16'h00ff));
    {fix_dword_cnt, len_units, float_xfer_cnt, int_xfer_cnt} <= 8'(rnd(16'h00ff));
    {fetch_multi, is_float, float_long, float_both_dirs, imm_own_ovh} <= 5'(rnd(16'h001f));
    op1_plain_cost  <= rnd(16'h003f);
    op2_plain_cost  <= rnd(16'h003f);
    ovh_n1          <= rnd(16'h00ff);
    ovh_n2          <= rnd(16'h00ff);
    ovh_reg_n1      <= rnd(16'h00ff);
    ovh_reg_n2      <= rnd(16'h00ff);
    fetch_cycles    <= rnd(16'h001f);
    parallel_cpu_cycles     <= rnd(16'h007f);
    coprocessor_exec_cycles <= rnd(16'h007f);
  endtask

  task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  // one descriptor per edge, results checked one edge later
  task automatic run_test(input string name, input logic crn, input int n);
    for (int i = 0; i <= n; i++)
    begin
      @(posedge mclk);
      drive(crn, i < n);
      #1;
      check1("result_valid_r", exp_v, result_valid_r);
      check16("total_exec_min_r", exp_min, total_exec_min_r);
      check16("total_exec_max_r", exp_max, total_exec_max_r);
      check16("flush_point_r", exp_fp, flush_point_r);
      calc_expected();
    end
    $display("test %s done", name);
  endtask

  task automatic results();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // hang guard, well above the 775 cycles used
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      results();
    end
  end

  initial
  begin
    seed = 32'h6530e2b3;
    {failures, n_compared, cycles} = '0;
    {exp_min, exp_max, exp_fp, exp_v} = '0;
    resetn = 1'b0;
    drive(1'b0, 1'b0);
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    run_test("random", 1'b0, 600);
    run_test("scaled_flush_corners", 1'b1, 150);
    results();
  end
endmodule // testbench

`default_nettype wire
